/* pprh_pkg.sv */
package pprh_pkg;
	localparam int NMC    = 8;
	localparam int TERM_W = 17;

	// Byte addresses of the register port
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_PRELOAD = 8'h04;
	localparam logic [7:0] A_STATUS  = 8'h08;
	localparam logic [7:0] A_TERM0   = 8'h10;
	localparam logic [7:0] A_SIG0    = 8'h40;
	localparam logic [7:0] A_SIG1    = 8'h44;

	// Field positions
	localparam int CTRL_PDEN  = 0;
	localparam int CTRL_SEC   = 1;
	localparam int CTRL_CLR   = 2;
	localparam int CTRL_MODE  = 8;
	localparam int CTRL_COE   = 16;
	localparam int PL_VAL     = 0;
	localparam int PL_MASK    = 8;
	localparam int ST_PD      = 8;
	localparam int ST_SEC     = 9;
	localparam int ST_REF     = 10;
	localparam int ST_BUSY    = 11;
	localparam int TERM_AUX   = 8;
	localparam int TERM_FB    = 9;

	// Values after reset
	localparam logic [7:0]  MC_RST   = 8'h00;
	localparam logic [7:0]  OUT_RST  = 8'hff;
	localparam logic [7:0]  CFG_RST  = 8'h00;
	localparam logic [31:0] WORD_RST = 32'h0;

	// Power-up reset interval, a longest time, so it rounds down
	localparam int CLK_NS      = 10;
	localparam int PUR_TIME_NS = 1000;
	localparam logic [6:0] PUR_CYC = 7'(PUR_TIME_NS / CLK_NS);

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pprh_req_t;

	typedef enum logic [1:0] {
		PS_INIT = 2'b00,
		PS_RUN  = 2'b01,
		PS_DOWN = 2'b10
	} pprh_state_t;
endpackage

/* pprh_rdmem.sv */
`timescale 1ns/1ps
`default_nettype none
module pprh_rdmem (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        wr,
	input  wire logic        waddr,
	input  wire logic [31:0] wdata,
	input  wire logic        rd,
	input  wire logic        raddr,
	input  wire logic        alt_sel,
	input  wire logic [31:0] alt_data,
	output var  logic [31:0] rdata
);
	import pprh_pkg::*;

	logic [31:0] mem_r [2];

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mem_r[0] <= WORD_RST;
			mem_r[1] <= WORD_RST;
		end
		else if (wr)
			mem_r[waddr] <= wdata;
	end

	// Read data stand for one cycle only
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata <= WORD_RST;
		else if (rd)
			rdata <= alt_sel ? alt_data : mem_r[raddr];
		else
			rdata <= WORD_RST;
	end
endmodule
`default_nettype wire

/* pprh_top.sv */
// What this block does
// [R1] Power-up clears all macrocell registers low
// [R2] Registered outputs read high after power-up
// [R3] Partner waits setup before first clock
// [R4] Clock sources stay quiet during power-up
// [R5] Enabled power-down pin high enters power-down
// [R6] Power-down freezes registers, logic and outputs
// [R7] Tri-stated outputs stay tri-stated while down
// [R8] Power-down ignores clock, enable, logic inputs
// [R9] Pin keepers keep working during power-down
// [R10] Without option, power-down pin is logic input
// [R11] Preload forces each register high or low
// [R12] Security bit blocks verify and preload
// [R13] 64-bit signature always readable
// [R14] Security bit is set last
// [R15] Undriven pins hold level, drivers override
// [R16] Power-down pin low resumes from held state
`timescale 1ns/1ps
`default_nettype none
module pprh_top (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire pprh_pkg::pprh_req_t req,
	output var  logic [31:0]         rdata,
	input  wire logic                dev_clk_pin,
	input  wire logic                oe_n_pin,
	input  wire logic                power_down_pin,
	input  wire logic [7:0]          in_pin,
	input  wire logic [7:0]          in_drv,
	input  wire logic [7:0]          io_in,
	input  wire logic [7:0]          io_drv,
	output var  logic [7:0]          io_out,
	output var  logic [7:0]          io_oe
);
	import pprh_pkg::*;

	function automatic logic term_hit(input logic [7:0] a);
		term_hit = (a >= A_TERM0) && (a <= A_TERM0 + 8'(4 * (NMC - 1))) &&
			(a[1:0] == 2'b00);
	endfunction

	pprh_state_t         st_r;
	logic [6:0]          por_cnt_r;
	logic [7:0]          mc_r;
	logic                pd_en_r;
	logic                sec_r;
	logic                ref_r;
	logic [7:0]          mode_r;
	logic [7:0]          coe_r;
	logic [TERM_W-1:0]   term_r [NMC];
	logic [7:0]          in_keep_r;
	logic [7:0]          io_keep_r;
	logic                dclk_q_r;
	logic [7:0]          in_lvl;
	logic [7:0]          io_lvl;
	logic [7:0]          sum;
	logic [TERM_W-1:0]   arr_in;
	logic                clk_rise;
	logic                run;
	logic                wr_ctrl;
	logic                wr_pl;
	logic                wr_term;
	logic                wr_sig;
	logic                rd_term;
	logic                sec_op;
	logic [2:0]          tidx;
	logic [7:0]          toff;
	logic [31:0]         alt_data;
	logic                alt_sel;

	assign run      = (st_r == PS_RUN);
	// Term index counts from the first term word, not from address zero
	assign toff     = req.addr - A_TERM0;
	assign tidx     = toff[4:2];
	assign wr_ctrl  = req.wr && req.addr == A_CTRL;
	assign wr_pl    = req.wr && req.addr == A_PRELOAD;
	assign wr_term  = req.wr && term_hit(req.addr);
	assign rd_term  = req.rd && term_hit(req.addr);
	assign wr_sig   = req.wr && (req.addr == A_SIG0 || req.addr == A_SIG1);
	assign sec_op   = sec_r && (wr_pl || wr_term || rd_term || wr_sig);
	// Only edges seen outside power-up and power-down reach the cells
	assign clk_rise = dev_clk_pin && !dclk_q_r && run; // see [R8] see [R4]

	// Pins: an external driver overrides the held level
	genvar g;
	generate
		for (g = 0; g < NMC; g++)
		begin : g_pin
			assign in_lvl[g] = in_drv[g] ? in_pin[g] : in_keep_r[g]; // see [R15]
			assign io_lvl[g] = io_oe[g] ? io_out[g] :
				(io_drv[g] ? io_in[g] : io_keep_r[g]);
		end
	endgenerate

	// Feedback: register for registered cells, pin for combinational
	always_comb
	begin
		arr_in = '0;
		arr_in[7:0] = in_lvl;
		arr_in[TERM_AUX] = pd_en_r ? 1'b0 : power_down_pin; // see [R10]
		for (int i = 0; i < NMC; i++)
			arr_in[TERM_FB + i] = mode_r[i] ? io_lvl[i] : mc_r[i];
	end

	generate
		for (g = 0; g < NMC; g++)
		begin : g_sum
			assign sum[g] = ^(arr_in & term_r[g]);
		end
	endgenerate

	// Keepers track the resolved pin level even while powered down
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			in_keep_r <= CFG_RST;
			io_keep_r <= CFG_RST;
		end
		else
		begin
			in_keep_r <= in_lvl; // see [R9] see [R15]
			io_keep_r <= io_lvl; // see [R9]
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			dclk_q_r <= 1'b0;
		else
			dclk_q_r <= dev_clk_pin;
	end

	// Power state; the count stands in for the delay after the supply
	// threshold, during which the clock sources must not move
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r      <= PS_INIT;
			por_cnt_r <= '0;
		end
		else
		begin
			case (st_r)
				PS_INIT:
				begin
					por_cnt_r <= por_cnt_r + 7'd1;
					if (por_cnt_r == PUR_CYC - 7'd1)
						st_r <= PS_RUN; // see [R4] see [R3]
				end
				PS_RUN:
					if (pd_en_r && power_down_pin)
						st_r <= PS_DOWN; // see [R5]
				PS_DOWN:
					if (!(pd_en_r && power_down_pin))
						st_r <= PS_RUN; // see [R16]
				default:
					st_r <= PS_INIT;
			endcase
		end
	end

	// Configuration; security sets once and only reset clears it
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pd_en_r <= 1'b0;
			sec_r   <= 1'b0;
			mode_r  <= CFG_RST;
			coe_r   <= CFG_RST;
		end
		else if (wr_ctrl)
		begin
			if (!sec_r)
			begin
				pd_en_r <= req.wdata[CTRL_PDEN];
				mode_r  <= req.wdata[CTRL_MODE +: 8];
				coe_r   <= req.wdata[CTRL_COE +: 8];
			end
			// Lockout acts at once, so setup must come first
			sec_r <= sec_r | req.wdata[CTRL_SEC]; // see [R14] see [R12]
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NMC; i++)
				term_r[i] <= '0;
		end
		else if (wr_term && !sec_r)
			term_r[tidx] <= req.wdata[TERM_W-1:0]; // see [R12]
	end

	// Refused flag: a new refusal wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ref_r <= 1'b0;
		else if (sec_op)
			ref_r <= 1'b1; // see [R12]
		else if (wr_ctrl && req.wdata[CTRL_CLR])
			ref_r <= 1'b0;
	end

	// Macrocells; async reset clears them with no clock edge
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			mc_r <= MC_RST; // see [R1]
		else if (run && wr_pl && !sec_r)
		begin
			for (int i = 0; i < NMC; i++)
				if (req.wdata[PL_MASK + i])
					mc_r[i] <= req.wdata[PL_VAL + i]; // see [R11]
		end
		else if (clk_rise)
			mc_r <= sum; // see [R6] see [R16]
	end

	// Pins follow inverted logic; frozen while down
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			io_out <= OUT_RST; // see [R2]
			io_oe  <= CFG_RST;
		end
		else if (st_r != PS_DOWN)
		begin
			for (int i = 0; i < NMC; i++)
			begin
				io_out[i] <= mode_r[i] ? ~sum[i] : ~mc_r[i]; // see [R2]
				io_oe[i]  <= mode_r[i] ? coe_r[i] : ~oe_n_pin;
			end
		end // see [R6] see [R7] see [R8]
	end

	// Readback: terms read zero once secured, signature always
	always_comb
	begin
		alt_sel  = 1'b1;
		alt_data = WORD_RST;
		if (term_hit(req.addr))
			alt_data = sec_r ? WORD_RST : 32'(term_r[tidx]); // see [R12]
		else if (req.addr == A_CTRL)
			alt_data = {8'h00, coe_r, mode_r, 6'h00, sec_r, pd_en_r};
		else if (req.addr == A_STATUS)
			alt_data = {20'h0, st_r == PS_INIT, ref_r, sec_r,
				st_r == PS_DOWN, mc_r};
		else if (req.addr == A_SIG0 || req.addr == A_SIG1)
			alt_sel = 1'b0; // see [R13]
	end

	pprh_rdmem u_rdmem (
		.clk      (clk),
		.rstn     (rstn),
		.wr       (wr_sig && !sec_r),
		.waddr    (req.addr[2]),
		.wdata    (req.wdata),
		.rd       (req.rd),
		.raddr    (req.addr[2]),
		.alt_sel  (alt_sel),
		.alt_data (alt_data),
		.rdata    (rdata)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	por_clear_a: assert property (st_r == PS_INIT |-> mc_r == MC_RST) // see [R1]
		else $error("registers not clear during power-up");
	out_high_a: assert property ((st_r == PS_INIT && mode_r == CFG_RST) // see [R2]
		|=> io_out == OUT_RST)
		else $error("outputs not high after power-up");
	pd_enter_a: assert property (run && pd_en_r && power_down_pin // see [R5]
		|=> st_r == PS_DOWN)
		else $error("power-down not entered");
	pd_freeze_a: assert property (st_r == PS_DOWN ##1 st_r == PS_DOWN // see [R6]
		|-> $stable(mc_r) && $stable(io_out))
		else $error("state moved while powered down");
	hiz_hold_a: assert property (st_r == PS_DOWN |=> $stable(io_oe)) // see [R7]
		else $error("enable changed while powered down");
	clk_block_a: assert property (st_r == PS_DOWN && dev_clk_pin // see [R8]
		&& !dclk_q_r |=> mc_r == $past(mc_r))
		else $error("clock edge taken while powered down");
	keeper_a: assert property (st_r == PS_DOWN && !in_drv[0] // see [R9]
		|=> in_keep_r[0] == $past(in_keep_r[0]))
		else $error("keeper lost level");
	pd_input_a: assert property (!pd_en_r && run |=> st_r != PS_DOWN) // see [R10]
		else $error("power-down without option");
	preload_a: assert property (run && wr_pl && !sec_r && // see [R11]
		req.wdata[PL_MASK] |=> mc_r[0] == $past(req.wdata[PL_VAL]))
		else $error("preload not applied");
	sec_read_a: assert property (sec_r && rd_term |=> rdata == WORD_RST // see [R12]
		&& ref_r)
		else $error("verify not blocked");
	resume_a: assert property (st_r == PS_DOWN && !power_down_pin // see [R16]
		|=> st_r == PS_RUN ##1 st_r == PS_RUN)
		else $error("no resume after power-down");

	pd_cycle_c: cover property (st_r == PS_DOWN ##[1:20] st_r == PS_RUN);
	preload_c: cover property (run && wr_pl && !sec_r);
	sec_sig_c: cover property (sec_r && req.rd && req.addr == A_SIG0);
endmodule
`default_nettype wire

/* pprh_sys_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pprh_sys_model (
	input  wire logic       clk,
	output var  logic       dev_clk_pin,
	output var  logic       oe_n_pin,
	output var  logic       power_down_pin,
	output var  logic [7:0] in_pin,
	output var  logic [7:0] in_drv,
	output var  logic [7:0] io_in,
	output var  logic [7:0] io_drv
);
	initial
	begin
		dev_clk_pin = 1'b0;
		oe_n_pin = 1'b0;
		power_down_pin = 1'b0;
		in_pin = 8'h00;
		in_drv = 8'hff;
		io_in = 8'h00;
		io_drv = 8'h00;
	end
	// Lines toggle while all eight are released, so a stale level never looks valid
	always @(posedge clk)
		if (io_drv == 8'h00)
			io_in <= ~io_in;
	// Inputs were set at least one cycle before the rise
	task automatic pulse();
		@(posedge clk);
		@(posedge clk) dev_clk_pin <= 1'b1;
		repeat (2) @(posedge clk);
		dev_clk_pin <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic drive(input logic pd, input logic oen,
		input logic [7:0] v, input logic [7:0] drv);
		@(posedge clk);
		power_down_pin <= pd;
		oe_n_pin <= oen;
		in_pin <= (v & drv) | (~in_pin & ~drv);
		in_drv <= drv;
	endtask
endmodule
`default_nettype wire

/* pld_powerdown_reset_hold_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pld_powerdown_reset_hold_tb;
	import pprh_pkg::*;
	logic        clk;
	logic        rstn;
	pprh_req_t   req;
	logic [31:0] rdata;
	logic        dev_clk_pin;
	logic        oe_n_pin;
	logic        power_down_pin;
	logic [7:0]  in_pin;
	logic [7:0]  in_drv;
	logic [7:0]  io_in;
	logic [7:0]  io_drv;
	logic [7:0]  io_out;
	logic [7:0]  io_oe;
	int          errors;
	int          n_compared;
	pprh_top u_pprh_top (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
		.dev_clk_pin(dev_clk_pin), .oe_n_pin(oe_n_pin),
		.power_down_pin(power_down_pin), .in_pin(in_pin), .in_drv(in_drv),
		.io_in(io_in), .io_drv(io_drv), .io_out(io_out), .io_oe(io_oe));
	pprh_sys_model u_pprh_sys_model (.clk(clk), .dev_clk_pin(dev_clk_pin),
		.oe_n_pin(oe_n_pin), .power_down_pin(power_down_pin),
		.in_pin(in_pin), .in_drv(in_drv), .io_in(io_in), .io_drv(io_drv));
	initial
		clk = 1'b0;
	always #5 clk = ~clk;
	task automatic summarize();
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) req.wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk) req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk) req.rd <= 1'b0;
		#1 check(rdata, exp);
	endtask
	task automatic t_reset();
		rstn = 1'b0;
		repeat (3) @(posedge clk);
		check({24'h0, io_out}, 32'hff);
		check({24'h0, io_oe}, 32'h00);
		rstn <= 1'b1;
		rdc(A_STATUS, 32'h800);
		check({24'h0, io_out}, 32'hff);
		repeat (100) @(posedge clk);
		rdc(A_STATUS, 32'h000);
	endtask
	task automatic t_preload();
		wr(A_PRELOAD, 32'h0000_ff5a);
		rdc(A_STATUS, 32'h05a);
		wr(A_PRELOAD, 32'h0000_0fa5);
		rdc(A_STATUS, 32'h055);
		check({24'h0, io_out}, 32'haa);
		check({24'h0, io_oe}, 32'hff);
	endtask
	task automatic t_keeper();
		wr(A_TERM0, 32'h1);
		u_pprh_sys_model.drive(1'b0, 1'b0, 8'h01, 8'hff);
		u_pprh_sys_model.drive(1'b0, 1'b0, 8'h00, 8'h00);
		u_pprh_sys_model.pulse();
		rdc(A_STATUS, 32'h001);
		u_pprh_sys_model.drive(1'b0, 1'b0, 8'h00, 8'hff);
		u_pprh_sys_model.pulse();
		rdc(A_STATUS, 32'h000);
	endtask
	task automatic t_pdown();
		wr(A_PRELOAD, 32'h0000_ff3c);
		wr(A_CTRL, 32'h1);
		u_pprh_sys_model.drive(1'b0, 1'b1, 8'h01, 8'hff);
		repeat (3) @(posedge clk);
		check({24'h0, io_oe}, 32'h00);
		u_pprh_sys_model.drive(1'b1, 1'b1, 8'h01, 8'hff);
		rdc(A_STATUS, 32'h13c);
		u_pprh_sys_model.drive(1'b1, 1'b0, 8'h00, 8'hff);
		u_pprh_sys_model.pulse();
		check({24'h0, io_out}, 32'hc3);
		check({24'h0, io_oe}, 32'h00);
		rdc(A_STATUS, 32'h13c);
		u_pprh_sys_model.drive(1'b0, 1'b0, 8'h01, 8'hff);
		repeat (3) @(posedge clk);
		check({24'h0, io_oe}, 32'hff);
		rdc(A_STATUS, 32'h03c);
		u_pprh_sys_model.pulse();
		rdc(A_STATUS, 32'h001);
	endtask
	task automatic t_nopd();
		wr(A_CTRL, 32'h0);
		wr(A_TERM0 + 8'h04, 32'h100);
		u_pprh_sys_model.drive(1'b1, 1'b0, 8'h00, 8'hff);
		u_pprh_sys_model.pulse();
		rdc(A_STATUS, 32'h002);
		u_pprh_sys_model.drive(1'b0, 1'b0, 8'h00, 8'hff);
	endtask
	task automatic t_secure();
		wr(A_SIG0, 32'h1234_5678);
		wr(A_SIG1, 32'h9abc_def0);
		// Lockout is immediate, so it is the last setup write
		wr(A_CTRL, 32'h2);
		rdc(A_STATUS, 32'h202);
		wr(A_PRELOAD, 32'h0000_ffff);
		rdc(A_STATUS, 32'h602);
		rdc(A_TERM0, 32'h0);
		rdc(A_SIG0, 32'h1234_5678);
		rdc(A_SIG1, 32'h9abc_def0);
		@(posedge clk);
		#1 check(rdata, 32'h0);
	endtask
	initial
	begin
		errors = 0;
		n_compared = 0;
		req = '0;
		t_reset();
		t_preload();
		t_keeper();
		t_pdown();
		t_nopd();
		t_secure();
		summarize();
	end
	initial
	begin
		#200000;
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
